/* hdl/cdto_pkg.sv */
// Functional notes
// - override clear: value read-only, shows auto
// - override set: value writable, transmitter uses it
// - defaults suit 800 Mbps, auto follows rate
// - offset 0x61 clock zero, reset 0x1B
// - offset 0x62 clock trail, reset 0x0B
// - offset 0x63 clock post, reset 0x0A
// - offset 0x64 data prepare, reset 0x06
// - offset 0x65 data zero, reset 0x0C
// - all override bits reset to zero
// - offset 0x66 data trail, reset 0x08; bit 7 of each register selects auto or manual
package cdto_pkg;
  localparam int NUM_REGS = 6;
  localparam int VAL_W    = 7;
  localparam int OV_BIT   = 7;
  localparam int ADDR_W   = 12;
  // register indices: the byte address on the bus is four times these
  localparam logic [ADDR_W-1:0] IDX_CLK_ZERO   = 12'h0061;
  localparam logic [ADDR_W-1:0] IDX_CLK_TRAIL  = 12'h0062;
  localparam logic [ADDR_W-1:0] IDX_CLK_POST   = 12'h0063;
  localparam logic [ADDR_W-1:0] IDX_DATA_PREP  = 12'h0064;
  localparam logic [ADDR_W-1:0] IDX_DATA_ZERO  = 12'h0065;
  localparam logic [ADDR_W-1:0] IDX_DATA_TRAIL = 12'h0066;
  localparam logic [ADDR_W-1:0] IDX_BASE       = IDX_CLK_ZERO;
  localparam logic [VAL_W-1:0] RST_CLK_ZERO   = 7'h1B;
  localparam logic [VAL_W-1:0] RST_CLK_TRAIL  = 7'h0B;
  localparam logic [VAL_W-1:0] RST_CLK_POST   = 7'h0A;
  localparam logic [VAL_W-1:0] RST_DATA_PREP  = 7'h06;
  localparam logic [VAL_W-1:0] RST_DATA_ZERO  = 7'h0C;
  localparam logic [VAL_W-1:0] RST_DATA_TRAIL = 7'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hdl/cdto_regs.sv */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module cdto_regs
  import cdto_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [NUM_REGS*VAL_W-1:0] auto_value_i,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr_i,
  input  wire logic                    s_axi_awvalid_i,
  output logic                         s_axi_awready_o,
  input  wire logic [31:0]             s_axi_wdata_i,
  input  wire logic [3:0]              s_axi_wstrb_i,
  input  wire logic                    s_axi_wvalid_i,
  output logic                         s_axi_wready_o,
  output logic [1:0]                   s_axi_bresp_o,
  output logic                         s_axi_bvalid_o,
  input  wire logic                    s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr_i,
  input  wire logic                    s_axi_arvalid_i,
  output logic                         s_axi_arready_o,
  output logic [31:0]                  s_axi_rdata_o,
  output logic [1:0]                   s_axi_rresp_o,
  output logic                         s_axi_rvalid_o,
  input  wire logic                    s_axi_rready_i,
  output logic [NUM_REGS-1:0]          override_o,
  output logic [NUM_REGS*VAL_W-1:0]    applied_value_o
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // indices are word numbers; the two low address bits are ignored
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = (a[ADDR_W-1:2] >= 10'(IDX_BASE)) &&
          (a[ADDR_W-1:2] <= 10'(IDX_DATA_TRAIL));
  endfunction
  function automatic logic [2:0] slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = {2'h0, a[ADDR_W-1:2]} - IDX_BASE;
    slot = d[2:0];
  endfunction

  localparam logic [NUM_REGS*VAL_W-1:0] RST_VALS =
    {RST_DATA_TRAIL, RST_DATA_ZERO, RST_DATA_PREP,
     RST_CLK_POST, RST_CLK_TRAIL, RST_CLK_ZERO};

  function automatic logic slot_is(input logic [ADDR_W-1:0] a,
                                   input int                i);
    slot_is = hit(a) && (slot(a) == 3'(i));
  endfunction

  function automatic logic [VAL_W-1:0] field(
    input logic [NUM_REGS*VAL_W-1:0] v,
    input int                        i);
    field = v[i*VAL_W +: VAL_W];
  endfunction

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the slot decode is three bits wide and each value field must sit
  // below the override bit, so other sizes need a new decode
  if (NUM_REGS > 8) begin : g_regs_chk
    $error("cdto_regs: at most eight timing registers");
  end
  if (VAL_W > OV_BIT) begin : g_val_chk
    $error("cdto_regs: value field overlaps the override bit");
  end
  if (ADDR_W != 12) begin : g_addr_chk
    $error("cdto_regs: the index decode expects twelve address bits");
  end

  // ----------------------------------------
  // auto value sync (from the rate logic)
  // ----------------------------------------
  // the rate logic changes these rarely and holds them for many cycles,
  // so a plain two-stage sync is enough; a word that moves while it is
  // sampled can show a mixed value for a single cycle
  logic [NUM_REGS*VAL_W-1:0] auto_s1_q;
  logic [NUM_REGS*VAL_W-1:0] auto_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_s1_q <= RST_VALS;
      auto_q    <= RST_VALS;
    end else begin
      auto_s1_q <= auto_value_i;
      auto_q    <= auto_s1_q;
    end
  end

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic              wstrb0_q;
  logic              do_write;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
  logic              aw_take;
  logic              w_take;
  assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take  = s_axi_wvalid_i && s_axi_wready_o;

  // a beat waits here until its partner arrives; the write lands only
  // once both are in and the previous answer has been taken

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_hold_q <= 1'b0;
      wdata_q  <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold_q <= 1'b1;
      wdata_q  <= s_axi_wdata_i;
      wstrb0_q <= s_axi_wstrb_i[0];
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  // ready drops once a beat is held and returns with the write strobe,
  // so one address and one data beat at most wait inside the block
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b1;
    end else begin
      s_axi_awready_o <= !(aw_hold_q || aw_take) || do_write;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_wready_o <= 1'b1;
    end else begin
      s_axi_wready_o <= !(w_hold_q || w_take) || do_write;
    end
  end

  // ----------------------------------------
  // write response
  // ----------------------------------------
  // one answer per write, mapped or not
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // unmapped writes change nothing and report an error
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bresp_o <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp_o <= hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // timing registers
  // ----------------------------------------
  logic [NUM_REGS-1:0]       ov_q;
  logic [NUM_REGS*VAL_W-1:0] man_q;
  logic                      wr_hit;
  logic [2:0]                wr_slot;
  // a write with its low byte lane off is answered but changes nothing
  assign wr_hit  = do_write && wstrb0_q && hit(awaddr_q);
  assign wr_slot = slot(awaddr_q);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ov_q <= '0;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_hit && wr_slot == 3'(i)) begin
          ov_q[i] <= wdata_q[OV_BIT];
        end
      end
    end
  end

  // value bits written while the override is clear are dropped, and
  // setting it copies the shown value, so the transmitter never jumps
  // to a stale manual value
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      man_q <= RST_VALS;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_hit && wr_slot == 3'(i)) begin
          if (wdata_q[OV_BIT] && ov_q[i]) begin
            man_q[i*VAL_W +: VAL_W] <= wdata_q[VAL_W-1:0];
          end else if (wdata_q[OV_BIT]) begin
            man_q[i*VAL_W +: VAL_W] <= field(auto_q, i);
          end
        end
      end
    end
  end

  // software reads the same value that the transmitter applies

  // select auto or manual; auto tracks rate
  logic [NUM_REGS*VAL_W-1:0] shown;
  always_comb begin
    shown = '0;
    for (int i = 0; i < NUM_REGS; i++)
      shown[i*VAL_W +: VAL_W] = ov_q[i] ? man_q[i*VAL_W +: VAL_W]
                                        : auto_q[i*VAL_W +: VAL_W];
  end

  // ----------------------------------------
  // outputs to the transmitter
  // ----------------------------------------
  // registered once more so the transmitter sees flop outputs only;
  // a change reaches it one cycle after the register updates
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      override_o <= '0;
    end else begin
      override_o <= ov_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      applied_value_o <= RST_VALS;
    end else begin
      applied_value_o <= shown;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic ar_take;
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

  // unmapped addresses read as zero; bits above the override bit are zero
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    read_word = 32'h0000_0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (slot_is(a, i)) begin
        read_word = 32'({ov_q[i], field(shown, i)});
      end
    end
  endfunction

  // one read in flight: the address is refused until the data is taken
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
    end else if (ar_take) begin
      s_axi_arready_o <= 1'b0;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid_o <= 1'b1;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rresp_o <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rresp_o <= hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // data is frozen while it is offered, so a slow reader sees one value
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rdata_o <= '0;
    end else if (ar_take) begin
      s_axi_rdata_o <= read_word(s_axi_araddr_i);
    end
  end
endmodule
`default_nettype wire

/* bench/cdto_regs_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module cdto_regs_checker (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       s_axi_awvalid_i,
  input wire logic       s_axi_awready_o,
  input wire logic       s_axi_wvalid_i,
  input wire logic       s_axi_wready_o,
  input wire logic       s_axi_bvalid_o,
  input wire logic       s_axi_bready_i,
  input wire logic       s_axi_arvalid_i,
  input wire logic       s_axi_arready_o,
  input wire logic       s_axi_rvalid_o,
  input wire logic       s_axi_rready_i,
  input wire logic [5:0] override_o
);
  // ----
  // bus and override checks
  // ----
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence wr_take_s;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  wr_answer_a: assert property (wr_take_s |-> ##[2:3] s_axi_bvalid_o)
    else $error("write response missing");
  rd_answer_a: assert property (rd_take_s |-> ##[1:2] s_axi_rvalid_o)
    else $error("read response missing");
  wr_latency_a: assert property (
    wr_take_s |=> !s_axi_bvalid_o)
    else $error("write answered too early");
  rd_block_a: assert property (
    s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while response pending");
  b_done_a: assert property (
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  r_done_a: assert property (
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read response repeated");
  ov_reset_a: assert property ($rose(rst_n_i) |-> override_o == 6'h00)
    else $error("override set after reset");
  // override may only move right after a write completes
  ov_cause_a: assert property (
    $changed(override_o) |-> $past(s_axi_bvalid_o))
    else $error("override changed without write");
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cdto_pkg::*;
  logic             core_clk_i = 1'h0;
  logic             rst_n_i = 1'h0;
  logic [41:0]      auto_q = {RST_DATA_TRAIL, RST_DATA_ZERO, RST_DATA_PREP,
                              RST_CLK_POST, RST_CLK_TRAIL, RST_CLK_ZERO};
  logic [11:0]      aw = 12'h000;
  logic [11:0]      ar = 12'h000;
  logic [31:0]      wd = 32'h0000_0000;
  logic [3:0]       ws = 4'hf;
  logic             awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  wire logic        awr, wrd, bv, arr, rv;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  wire logic [5:0]  ov;
  wire logic [41:0] ap;
  int               errors = 0, total_checks = 0, cyc = 0;
  always #2 core_clk_i = ~core_clk_i;
  cdto_regs uut (.core_clk_i, .rst_n_i, .auto_value_i(auto_q),
    .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .override_o(ov),
    .applied_value_o(ap));
  // ----
  // bus tasks
  // ----
  function automatic logic [11:0] adr(int i);
    return 12'((IDX_BASE + i) * 4);
  endfunction
  function automatic logic [6:0] au(int i);
    return auto_q[7*i +: 7];
  endfunction
  task automatic chk(input string n, input logic [41:0] x, g);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  // readies are seen as they were before this edge, so release is exact
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    @(posedge core_clk_i);
    aw  <= a;
    wd  <= {24'h00_0000, d};
    awv <= 1'h1;
    wv  <= 1'h1;
    bre <= 1'h1;
    do begin
      @(posedge core_clk_i);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
    end while (!bv);
    bre <= 1'h0;
    chk("bresp", 42'(e), 42'(br));
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] x,
                     input logic [1:0] e);
    @(posedge core_clk_i);
    ar  <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do begin
      @(posedge core_clk_i);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rre <= 1'h0;
    chk("rresp", 42'(e), 42'(rr));
    chk("rdata", 42'(x), 42'(rd));
  endtask
  // ----
  // scenarios
  // ----
  task automatic s_reset();
    for (int i = 0; i < NUM_REGS; i++) begin
      rdc(adr(i), {1'h0, au(i)}, RESP_OKAY);
    end
    chk("override", 42'h000_0000_0000, 42'(ov));
    chk("applied", auto_q, ap);
  endtask
  task automatic s_ro();
    @(posedge core_clk_i);
    auto_q <= {auto_q[34:0], auto_q[41:35]};
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < NUM_REGS; i++) begin
      wr(adr(i), 8'h55, RESP_OKAY);
      rdc(adr(i), {1'h0, au(i)}, RESP_OKAY);
    end
    chk("applied", auto_q, ap);
  endtask
  task automatic s_ov();
    for (int i = 0; i < NUM_REGS; i++) begin
      wr(adr(i), 8'h80, RESP_OKAY);
      rdc(adr(i), {1'h1, au(i)}, RESP_OKAY);
      wr(adr(i), 8'hc0 + 8'(i), RESP_OKAY);
      rdc(adr(i), 8'hc0 + 8'(i), RESP_OKAY);
      chk("value", 42'(7'h40 + 7'(i)), 42'(ap[7*i +: 7]));
      chk("override", 42'(6'h01 << i), 42'(ov));
      wr(adr(i), 8'h00, RESP_OKAY);
      rdc(adr(i), {1'h0, au(i)}, RESP_OKAY);
    end
  endtask
  task automatic s_bad();
    rdc(12'h000, 8'h00, RESP_SLVERR);
    wr(12'h19c, 8'hff, RESP_SLVERR);
    rdc(12'h19c, 8'h00, RESP_SLVERR);
  endtask
  task automatic s_strb();
    ws <= 4'he;
    wr(adr(0), 8'h80, RESP_OKAY);
    ws <= 4'hf;
    rdc(adr(0), {1'h0, au(0)}, RESP_OKAY);
    chk("override", 42'h000_0000_0000, 42'(ov));
  endtask
  task automatic s_rst();
    wr(adr(2), 8'h80, RESP_OKAY);
    rdc(adr(2), {1'h1, au(2)}, RESP_OKAY);
    @(posedge core_clk_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    @(posedge core_clk_i);
    chk("override", 42'h000_0000_0000, 42'(ov));
    rdc(adr(2), {1'h0, au(2)}, RESP_OKAY);
  endtask
  task automatic end_of_test(input int hang);
    errors += hang;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) end_of_test(1);
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    s_reset();
    s_ro();
    s_ov();
    s_strb();
    s_rst();
    s_bad();
    end_of_test(0);
  end
endmodule
bind cdto_regs cdto_regs_checker chk_u (.*);
`default_nettype wire
